// *** link_partner_model.sv ***
`default_nettype none
module link_partner_model (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_slow,
  input  wire logic i_restart,
  input  wire logic i_power_down,
  input  wire logic i_an_enable,
  input  wire logic i_tx_disable,
  output logic      o_an_done,
  output logic      o_link_up
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_ff;
  int limit;
  // slow mode keeps negotiation open across several host reads
  assign limit = i_slow ? 40 : 4;
  always_ff @(posedge i_mclk) begin
    if (i_reset || i_restart || i_power_down || !i_an_enable) begin
      cnt_ff <= 0;
    end else if (cnt_ff < limit) begin
      cnt_ff <= cnt_ff + 1;
    end
  end
  assign o_an_done = i_an_enable && (cnt_ff >= limit);
  // a silent transmitter drops the link; forced mode brings it up without negotiation
  assign o_link_up = !i_power_down && !i_tx_disable &&
                     (i_an_enable ? o_an_done : 1'b1);
endmodule : link_partner_model
`default_nettype wire

// *** phy_cfg_if.sv ***
`default_nettype none
interface phy_cfg_if;
  logic        wr_ctrl;
  logic        wr_adv;
  logic [15:0] wr_data;
  logic [1:0]  wr_be;
  logic        alias_ctrl_we;
  logic [15:0] alias_ctrl_data;
  logic        alias_adv_we;
  logic [15:0] alias_adv_data;
  logic [15:0] ctrl;
  logic [15:0] adv;
  logic        restart;

  modport store (
    input  wr_ctrl, wr_adv, wr_data, wr_be,
    input  alias_ctrl_we, alias_ctrl_data, alias_adv_we, alias_adv_data,
    output ctrl, adv, restart
  );
  modport bank (
    output wr_ctrl, wr_adv, wr_data, wr_be,
    output alias_ctrl_we, alias_ctrl_data, alias_adv_we, alias_adv_data,
    input  ctrl, adv, restart
  );
endinterface : phy_cfg_if
`default_nettype wire

// *** phy_cfg_store.sv ***
`default_nettype none
module phy_cfg_store (
  input wire logic i_mclk,
  input wire logic i_reset,
  phy_cfg_if.store cfg
);

  logic [15:0] ctrl_ff;
  logic [15:0] adv_ff;
  logic        restart_ff;
  logic [15:0] nxt_ctrl;
  logic [15:0] nxt_adv;
  logic        nxt_restart;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] data,
                                        input logic [1:0]  be,
                                        input logic [15:0] wmask);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~m) | (data & m);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // alias write first, host write on top: the later writer wins a clash
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_adv  = adv_ff;
    if (cfg.alias_ctrl_we) begin
      nxt_ctrl = merge(nxt_ctrl, cfg.alias_ctrl_data, 2'h3,
                       port_phy_mii_pkg::CTRL_ALIAS_MASK); // [R18]
    end
    if (cfg.wr_ctrl) begin
      nxt_ctrl = merge(nxt_ctrl, cfg.wr_data, cfg.wr_be,
                       port_phy_mii_pkg::CTRL_WMASK);
    end
    if (cfg.alias_adv_we) begin
      nxt_adv = merge(nxt_adv, cfg.alias_adv_data, 2'h3,
                      port_phy_mii_pkg::ADV_ALIAS_MASK); // [R18]
    end
    if (cfg.wr_adv) begin
      nxt_adv = merge(nxt_adv, cfg.wr_data, cfg.wr_be,
                      port_phy_mii_pkg::ADV_WMASK); // [R14] [R15]
    end
  end

  always_comb begin
    nxt_restart = (cfg.wr_ctrl && cfg.wr_be[1] &&
                   cfg.wr_data[port_phy_mii_pkg::CTRL_AN_RESTART]) ||
                  (cfg.alias_ctrl_we &&
                   cfg.alias_ctrl_data[port_phy_mii_pkg::CTRL_AN_RESTART]);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_ff <= port_phy_mii_pkg::CTRL_RESET; // [R2] [R3] [R5] [R6] [R17]
      adv_ff  <= port_phy_mii_pkg::ADV_RESET; // [R14] [R15]
    end else begin
      ctrl_ff <= nxt_ctrl;
      adv_ff  <= nxt_adv;
    end
  end

  // one-cycle pulse; bit 9 lies outside both write masks, so it always reads back 0
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= nxt_restart; // [R4]
    end
  end

  assign cfg.ctrl    = ctrl_ff;
  assign cfg.adv     = adv_ff;
  assign cfg.restart = restart_ff;

endmodule : phy_cfg_store
`default_nettype wire

// *** port_phy_mii_pkg.sv ***
`default_nettype none
package port_phy_mii_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // byte addresses of the 16-bit words on the host interface
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h4E;
  localparam logic [ADDR_W-1:0] OFS_ID_LO = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_ID_HI = 8'h52;
  localparam logic [ADDR_W-1:0] OFS_ADV   = 8'h54;

  // basic control word fields
  localparam int CTRL_LOOPBACK   = 14;
  localparam int CTRL_SPEED_100  = 13;
  localparam int CTRL_AN_ENABLE  = 12;
  localparam int CTRL_POWER_DOWN = 11;
  localparam int CTRL_AN_RESTART = 9;
  localparam int CTRL_FULL_DUPLX = 8;
  localparam int CTRL_XOVER_VAR  = 5;
  localparam int CTRL_FORCE_XOVR = 4;
  localparam int CTRL_NO_AUTO_X  = 3;
  localparam int CTRL_TX_DISABLE = 1;

  // basic status word fields
  localparam int STAT_T4_ABLE = 15;
  localparam int STAT_ABL_HI  = 14;
  localparam int STAT_ABL_LO  = 11;
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_AN_ABLE = 3;
  localparam int STAT_LINK_UP = 2;
  localparam int STAT_EXT_REG = 0;

  // advertisement word fields
  localparam int ADV_PAUSE   = 10;
  localparam int ADV_ABIL_HI = 8;
  localparam int ADV_ABIL_LO = 5;

  localparam logic [DATA_W-1:0] CTRL_RESET      = 16'h3120;
  localparam logic [DATA_W-1:0] CTRL_WMASK      = 16'h793F;
  localparam logic [DATA_W-1:0] CTRL_ALIAS_MASK = 16'h793E;
  localparam logic [DATA_W-1:0] ADV_RESET       = 16'h05E0;
  localparam logic [DATA_W-1:0] ADV_WMASK       = 16'h07E0;
  localparam logic [DATA_W-1:0] ADV_ALIAS_MASK  = 16'h05E0;
  localparam logic [DATA_W-1:0] ADV_SELECTOR    = 16'h0001;
  localparam logic [DATA_W-1:0] STAT_FIXED      = 16'h7808;

endpackage : port_phy_mii_pkg
`default_nettype wire

// *** port_phy_mii_register_bank.sv ***
// How it works
// R1 - control bit 14 loops second port far end
// R2 - control bit 13 forces 100 or 10
// R3 - control bit 12 enables negotiation, resets set
// R4 - control bit 9 restarts negotiation, self clears
// R5 - control bit 8 forces duplex, resets set
// R6 - control bit 5 picks crossover variant
// R7 - bit 3 disables auto crossover, 4 forces
// R8 - control bit 1 disables transmitter
// R9 - status 14..11 read one, 15 zero
// R10 - status bit 5 shows negotiation complete
// R11 - status bit 3 reads constant one
// R12 - status bit 0 reads zero
// R13 - identifier readable as low and high words
// R14 - advertise bit 10 offers pause, resets set
// R15 - advertise bits 8..5 offer abilities, set
// R16 - status bit 2 shows current link
// R17 - control bit 11 powers down the PHY
// R18 - aliased bits share storage with alias
`default_nettype none
module port_phy_mii_register_bank #(
  // identifier values are arbitrary
  parameter logic [15:0] PHY_ID_LOW  = 16'h0A5A,
  parameter logic [15:0] PHY_ID_HIGH = 16'h00C3
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [1:0]  i_reg_be,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_ack,
  input  wire logic        i_alias_ctrl_we,
  input  wire logic [15:0] i_alias_ctrl_data,
  input  wire logic        i_alias_adv_we,
  input  wire logic [15:0] i_alias_adv_data,
  input  wire logic        i_autoneg_done,
  input  wire logic        i_link_up,
  output logic             o_far_loopback,
  output logic             o_force_100,
  output logic             o_autoneg_enable,
  output logic             o_power_down,
  output logic             o_autoneg_restart,
  output logic             o_force_full,
  output logic             o_crossover_variant_select,
  output logic             o_force_crossed,
  output logic             o_disable_auto_crossover,
  output logic             o_tx_disable,
  output logic             o_adv_pause,
  output logic      [3:0]  o_adv_abilities
);

  phy_cfg_if cfg ();

  logic [15:0] rdata_ff;
  logic        ack_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] status_word;

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    // word aligned: the low address bit is ignored; i_reg_be selects the byte lanes
    return addr[7:1] == ofs[7:1];
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // storage for control and advertisement words

  assign cfg.wr_ctrl = i_reg_wr && hit(i_reg_addr, port_phy_mii_pkg::OFS_CTRL);
  assign cfg.wr_adv  = i_reg_wr && hit(i_reg_addr, port_phy_mii_pkg::OFS_ADV);
  assign cfg.wr_data = i_reg_wdata;
  assign cfg.wr_be   = i_reg_be;
  assign cfg.alias_ctrl_we   = i_alias_ctrl_we;
  assign cfg.alias_ctrl_data = i_alias_ctrl_data;
  assign cfg.alias_adv_we    = i_alias_adv_we;
  assign cfg.alias_adv_data  = i_alias_adv_data;

  phy_cfg_store u_store (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .cfg     (cfg.store)
  );

  ////////////////////////////////////////////////////////////////////////
  // control outputs are the stored flops themselves

  assign o_far_loopback    = cfg.ctrl[port_phy_mii_pkg::CTRL_LOOPBACK]; // [R1]
  assign o_force_100       = cfg.ctrl[port_phy_mii_pkg::CTRL_SPEED_100]; // [R2]
  assign o_autoneg_enable  = cfg.ctrl[port_phy_mii_pkg::CTRL_AN_ENABLE]; // [R3]
  assign o_power_down      = cfg.ctrl[port_phy_mii_pkg::CTRL_POWER_DOWN]; // [R17]
  assign o_autoneg_restart = cfg.restart; // [R4]
  assign o_force_full      = cfg.ctrl[port_phy_mii_pkg::CTRL_FULL_DUPLX]; // [R5]
  assign o_crossover_variant_select =
    cfg.ctrl[port_phy_mii_pkg::CTRL_XOVER_VAR]; // [R6]
  assign o_force_crossed   = cfg.ctrl[port_phy_mii_pkg::CTRL_FORCE_XOVR]; // [R7]
  assign o_disable_auto_crossover =
    cfg.ctrl[port_phy_mii_pkg::CTRL_NO_AUTO_X]; // [R7]
  assign o_tx_disable      = cfg.ctrl[port_phy_mii_pkg::CTRL_TX_DISABLE]; // [R8]
  assign o_adv_pause       = cfg.adv[port_phy_mii_pkg::ADV_PAUSE]; // [R14]
  assign o_adv_abilities   =
    cfg.adv[port_phy_mii_pkg::ADV_ABIL_HI:port_phy_mii_pkg::ADV_ABIL_LO]; // [R15]

  ////////////////////////////////////////////////////////////////////////
  // status word: fixed abilities plus live negotiation and link state

  always_comb begin
    status_word = port_phy_mii_pkg::STAT_FIXED; // [R9] [R11] [R12]
    status_word[port_phy_mii_pkg::STAT_AN_DONE] = i_autoneg_done; // [R10]
    status_word[port_phy_mii_pkg::STAT_LINK_UP] = i_link_up; // [R16]
  end

  ////////////////////////////////////////////////////////////////////////
  // read path; unmapped addresses and cycles without i_reg_rd return zero

  always_comb begin
    nxt_rdata = 16'h0000;
    if (i_reg_rd) begin
      if (hit(i_reg_addr, port_phy_mii_pkg::OFS_CTRL)) begin
        nxt_rdata = cfg.ctrl; // [R4]
      end else if (hit(i_reg_addr, port_phy_mii_pkg::OFS_STAT)) begin
        nxt_rdata = status_word;
      end else if (hit(i_reg_addr, port_phy_mii_pkg::OFS_ID_LO)) begin
        nxt_rdata = PHY_ID_LOW; // [R13]
      end else if (hit(i_reg_addr, port_phy_mii_pkg::OFS_ID_HI)) begin
        nxt_rdata = PHY_ID_HIGH; // [R13]
      end else if (hit(i_reg_addr, port_phy_mii_pkg::OFS_ADV)) begin
        nxt_rdata = cfg.adv | port_phy_mii_pkg::ADV_SELECTOR;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // every access is acknowledged one cycle later, mapped or not
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= i_reg_rd || i_reg_wr;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_reg_ack   = ack_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  logic rd_ctrl;
  logic rd_stat;
  logic rd_id_lo;
  logic rd_id_hi;
  logic rd_adv;
  logic wr_ctrl_hi;
  logic wr_ctrl_lo;
  logic wr_adv_hi;
  logic wr_adv_lo;
  logic host_only;

  assign rd_ctrl  = i_reg_rd && hit(i_reg_addr, port_phy_mii_pkg::OFS_CTRL);
  assign rd_stat  = i_reg_rd && hit(i_reg_addr, port_phy_mii_pkg::OFS_STAT);
  assign rd_id_lo = i_reg_rd && hit(i_reg_addr, port_phy_mii_pkg::OFS_ID_LO);
  assign rd_id_hi = i_reg_rd && hit(i_reg_addr, port_phy_mii_pkg::OFS_ID_HI);
  assign rd_adv   = i_reg_rd && hit(i_reg_addr, port_phy_mii_pkg::OFS_ADV);
  assign host_only  = !i_alias_ctrl_we && !i_alias_adv_we;
  assign wr_ctrl_hi = cfg.wr_ctrl && i_reg_be[1] && host_only;
  assign wr_ctrl_lo = cfg.wr_ctrl && i_reg_be[0] && host_only;
  assign wr_adv_hi  = cfg.wr_adv && i_reg_be[1] && host_only;
  assign wr_adv_lo  = cfg.wr_adv && i_reg_be[0] && host_only;

  sequence s_restart_pulse;
    o_autoneg_restart ##1 !o_autoneg_restart;
  endsequence

  sequence s_restart_request;
    cfg.wr_ctrl && i_reg_be[1] &&
      i_reg_wdata[port_phy_mii_pkg::CTRL_AN_RESTART];
  endsequence

  // the pulse only drops if no new request lands on the next edge
  a_restart_self_clear: assert property ( // [R4]
    s_restart_request ##1 (!cfg.wr_ctrl && !i_alias_ctrl_we)
      |-> s_restart_pulse)
    else $error("restart bit did not pulse for exactly one cycle");

  a_restart_needs_cause: assert property ( // [R4]
    o_autoneg_restart |-> $past(cfg.wr_ctrl && i_reg_be[1] &&
      i_reg_wdata[port_phy_mii_pkg::CTRL_AN_RESTART]) ||
      $past(i_alias_ctrl_we &&
      i_alias_ctrl_data[port_phy_mii_pkg::CTRL_AN_RESTART]))
    else $error("restart pulse without a restart write");

  a_loopback_write: assert property ( // [R1]
    wr_ctrl_hi |=> o_far_loopback ==
      $past(i_reg_wdata[port_phy_mii_pkg::CTRL_LOOPBACK]))
    else $error("loopback bit did not take written value");

  a_speed_an_write: assert property ( // [R2] [R3] [R17]
    wr_ctrl_hi |=>
      o_force_100 == $past(i_reg_wdata[port_phy_mii_pkg::CTRL_SPEED_100]) &&
      o_autoneg_enable ==
        $past(i_reg_wdata[port_phy_mii_pkg::CTRL_AN_ENABLE]) &&
      o_power_down == $past(i_reg_wdata[port_phy_mii_pkg::CTRL_POWER_DOWN]))
    else $error("speed, negotiation or power-down bit wrong after write");

  a_duplex_write: assert property ( // [R5]
    wr_ctrl_hi |=> o_force_full ==
      $past(i_reg_wdata[port_phy_mii_pkg::CTRL_FULL_DUPLX]))
    else $error("duplex bit did not take written value");

  a_crossover_write: assert property ( // [R6] [R7] [R8]
    wr_ctrl_lo |=>
      o_crossover_variant_select ==
        $past(i_reg_wdata[port_phy_mii_pkg::CTRL_XOVER_VAR]) &&
      o_force_crossed == $past(i_reg_wdata[port_phy_mii_pkg::CTRL_FORCE_XOVR])
      && o_disable_auto_crossover ==
        $past(i_reg_wdata[port_phy_mii_pkg::CTRL_NO_AUTO_X]) &&
      o_tx_disable == $past(i_reg_wdata[port_phy_mii_pkg::CTRL_TX_DISABLE]))
    else $error("crossover or transmit-disable bit wrong after write");

  a_ctrl_hold: assert property ( // [R1] [R2] [R8]
    !cfg.wr_ctrl && !i_alias_ctrl_we |=> $stable(o_far_loopback) &&
      $stable(o_force_100) && $stable(o_tx_disable))
    else $error("control bit changed without a write");

  a_status_abilities: assert property ( // [R9]
    rd_stat |=> o_reg_ack && o_reg_rdata[port_phy_mii_pkg::STAT_ABL_HI:
      port_phy_mii_pkg::STAT_ABL_LO] == 4'hF &&
      !o_reg_rdata[port_phy_mii_pkg::STAT_T4_ABLE])
    else $error("ability bits of status word wrong");

  a_status_fixed: assert property ( // [R11] [R12]
    rd_stat |=> o_reg_rdata[port_phy_mii_pkg::STAT_AN_ABLE] &&
      !o_reg_rdata[port_phy_mii_pkg::STAT_EXT_REG])
    else $error("fixed status bits wrong");

  a_status_live: assert property ( // [R10] [R16]
    rd_stat |=>
      o_reg_rdata[port_phy_mii_pkg::STAT_AN_DONE] == $past(i_autoneg_done) &&
      o_reg_rdata[port_phy_mii_pkg::STAT_LINK_UP] == $past(i_link_up))
    else $error("negotiation or link status not reported");

  a_ident_words: assert property ( // [R13]
    (rd_id_lo |=> o_reg_rdata == PHY_ID_LOW) and
    (rd_id_hi |=> o_reg_rdata == PHY_ID_HIGH))
    else $error("identifier word read back wrong");

  a_adv_write: assert property ( // [R14] [R15]
    wr_adv_hi && wr_adv_lo |=>
      o_adv_pause == $past(i_reg_wdata[port_phy_mii_pkg::ADV_PAUSE]) &&
      o_adv_abilities == $past(i_reg_wdata[port_phy_mii_pkg::ADV_ABIL_HI:
        port_phy_mii_pkg::ADV_ABIL_LO]))
    else $error("advertisement bits did not take written value");

  a_adv_readback: assert property ( // [R14] [R15]
    rd_adv && !i_alias_adv_we && !cfg.wr_adv |=>
      o_reg_rdata[port_phy_mii_pkg::ADV_PAUSE] == o_adv_pause &&
      o_reg_rdata[port_phy_mii_pkg::ADV_ABIL_HI:
        port_phy_mii_pkg::ADV_ABIL_LO] == o_adv_abilities &&
      o_reg_rdata[4:0] == 5'h01)
    else $error("advertisement word read back wrong");

  // a read two edges after an alias write, with a quiet edge between
  a_alias_shared: assert property ( // [R18]
    i_alias_ctrl_we && !cfg.wr_ctrl ##1 !cfg.wr_ctrl && !i_alias_ctrl_we
      ##1 rd_ctrl |=>
      o_reg_rdata[port_phy_mii_pkg::CTRL_LOOPBACK] ==
        $past(i_alias_ctrl_data[port_phy_mii_pkg::CTRL_LOOPBACK], 3))
    else $error("alias write not visible at control address");

  a_alias_adv: assert property ( // [R18]
    i_alias_adv_we && !cfg.wr_adv |=> o_adv_pause ==
      $past(i_alias_adv_data[port_phy_mii_pkg::ADV_PAUSE]))
    else $error("alias write not visible in advertisement");

  a_reset_defaults: assert property ( // [R2][R3][R5][R6][R14][R15][R17]
    $fell(i_reset) |-> o_force_100 && o_autoneg_enable && o_force_full &&
      o_crossover_variant_select && !o_power_down && o_adv_pause &&
      o_adv_abilities == 4'hF)
    else $error("control defaults wrong after reset");

  a_ctrl_restart_rd: assert property ( // [R4]
    rd_ctrl && !o_autoneg_restart |=>
      !o_reg_rdata[port_phy_mii_pkg::CTRL_AN_RESTART])
    else $error("restart bit read as one while idle");

  a_restart_idle: assert property ( // [R4]
    !cfg.wr_ctrl && !i_alias_ctrl_we |=> !o_autoneg_restart)
    else $error("restart pulse with no write to the control word");

  // ack follows each strobe one cycle later, so back-to-back strobes give back-to-back acks
  a_ack_follows: assert property ( // [R13]
    (i_reg_rd || i_reg_wr |=> o_reg_ack) and
    (!i_reg_rd && !i_reg_wr |=> !o_reg_ack))
    else $error("acknowledge did not follow the access strobe");

  a_rdata_idle: assert property ( // [R13]
    !i_reg_rd |=> o_reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");

  a_ctrl_hold_rest: assert property ( // [R3] [R5] [R6] [R7] [R17]
    !cfg.wr_ctrl && !i_alias_ctrl_we |=> $stable(o_autoneg_enable) &&
      $stable(o_power_down) && $stable(o_force_full) &&
      $stable(o_crossover_variant_select) && $stable(o_force_crossed) &&
      $stable(o_disable_auto_crossover))
    else $error("negotiation or crossover bit changed without a write");

  a_adv_hold: assert property ( // [R14] [R15]
    !cfg.wr_adv && !i_alias_adv_we |=> $stable(o_adv_pause) &&
      $stable(o_adv_abilities))
    else $error("advertisement bit changed without a write");

  a_alias_ctrl_hi: assert property ( // [R2] [R17] [R18]
    i_alias_ctrl_we && !cfg.wr_ctrl |=>
      o_power_down ==
        $past(i_alias_ctrl_data[port_phy_mii_pkg::CTRL_POWER_DOWN]) &&
      o_force_100 ==
        $past(i_alias_ctrl_data[port_phy_mii_pkg::CTRL_SPEED_100]))
    else $error("alias write lost a speed or power-down bit");

  a_alias_ctrl_lo: assert property ( // [R7] [R8] [R18]
    i_alias_ctrl_we && !cfg.wr_ctrl |=>
      o_tx_disable ==
        $past(i_alias_ctrl_data[port_phy_mii_pkg::CTRL_TX_DISABLE]) &&
      o_force_crossed ==
        $past(i_alias_ctrl_data[port_phy_mii_pkg::CTRL_FORCE_XOVR]))
    else $error("alias write lost a crossover or transmit bit");

  a_alias_adv_abil: assert property ( // [R15] [R18]
    i_alias_adv_we && !cfg.wr_adv |=> o_adv_abilities ==
      $past(i_alias_adv_data[port_phy_mii_pkg::ADV_ABIL_HI:
        port_phy_mii_pkg::ADV_ABIL_LO]))
    else $error("alias write not visible in advertised abilities");

endmodule : port_phy_mii_register_bank
`default_nettype wire

// *** port_phy_mii_register_bank_tb.sv ***
`default_nettype none
module port_phy_mii_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ID_LO = 16'h5A17; // arbitrary value
  localparam logic [15:0] ID_HI = 16'h0C3E; // arbitrary value
  localparam int          LIMIT = 20000;
  logic        i_mclk, i_reset, i_reg_wr, i_reg_rd, slow, an_done;
  logic        i_alias_ctrl_we, i_alias_adv_we, link_up, o_reg_ack;
  logic [7:0]  i_reg_addr;
  logic [1:0]  i_reg_be;
  logic [15:0] i_reg_wdata, i_alias_data, o_reg_rdata, out_c, out_a;
  logic        far, f100, an_en, pd, rst_p, full, xvar, fx, noax, txd;
  logic        pause;
  logic [3:0]  abil;
  int          errors = 0, samples_checked = 0, cyc = 0;
  int          ctrl_m, adv_m;
  logic [7:0]  addrs[10] = '{8'h4C, 8'h4E, 8'h50, 8'h52, 8'h54, 8'h56,
                            8'h4A, 8'h00, 8'h4D, 8'hFF};
  int          cbits[11] = '{14, 13, 12, 11, 8, 5, 4, 3, 2, 1, 0};

  port_phy_mii_register_bank #(
    .PHY_ID_LOW  (ID_LO),
    .PHY_ID_HIGH (ID_HI)
  ) i_port_phy_mii_register_bank (
    .i_mclk                     (i_mclk),
    .i_reset                    (i_reset),
    .i_reg_addr                 (i_reg_addr),
    .i_reg_be                   (i_reg_be),
    .i_reg_wr                   (i_reg_wr),
    .i_reg_rd                   (i_reg_rd),
    .i_reg_wdata                (i_reg_wdata),
    .o_reg_rdata                (o_reg_rdata),
    .o_reg_ack                  (o_reg_ack),
    .i_alias_ctrl_we            (i_alias_ctrl_we),
    .i_alias_ctrl_data          (i_alias_data),
    .i_alias_adv_we             (i_alias_adv_we),
    .i_alias_adv_data           (i_alias_data),
    .i_autoneg_done             (an_done),
    .i_link_up                  (link_up),
    .o_far_loopback             (far),
    .o_force_100                (f100),
    .o_autoneg_enable           (an_en),
    .o_power_down               (pd),
    .o_autoneg_restart          (rst_p),
    .o_force_full               (full),
    .o_crossover_variant_select (xvar),
    .o_force_crossed            (fx),
    .o_disable_auto_crossover   (noax),
    .o_tx_disable               (txd),
    .o_adv_pause                (pause),
    .o_adv_abilities            (abil)
  );

  link_partner_model i_link_partner_model (
    .i_mclk       (i_mclk),
    .i_reset      (i_reset),
    .i_slow       (slow),
    .i_restart    (rst_p),
    .i_power_down (pd),
    .i_an_enable  (an_en),
    .i_tx_disable (txd),
    .o_an_done    (an_done),
    .o_link_up    (link_up)
  );

  assign out_c = {1'b0, far, f100, an_en, pd, 2'b00, full, 2'b00, xvar, fx,
                  noax, 1'b0, txd, 1'b0};
  assign out_a = {5'h00, pause, 1'b0, abil, 5'h00};

  //////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
    cmp(got, exp);
  endtask : chk_rd

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    cmp(got, exp);
  endtask : chk_out

  task automatic chk_pulse(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask : chk_pulse

  //////////////////////////////////////////////////////////////////////////
  // one host access plus optional alias writes; model updated in step
  task automatic xfer(input bit wr, input bit rd, input logic [7:0] a,
                      input logic [1:0] be, input logic [15:0] d,
                      input bit ac = 0, input bit aa = 0,
                      input logic [15:0] ad = 16'h0000);
    logic [15:0] exp_rd;
    logic [15:0] lm;
    logic [7:0]  w;
    bit          rs;
    @(negedge i_mclk);
    i_reg_wr = wr;
    i_reg_rd = rd;
    i_reg_addr = a;
    i_reg_be = be;
    i_reg_wdata = d;
    i_alias_ctrl_we = ac;
    i_alias_adv_we = aa;
    i_alias_data = ad;
    w = {a[7:1], 1'b0};
    lm = {{8{be[1]}}, {8{be[0]}}};
    case (w)
      8'h4C:   exp_rd = 16'(ctrl_m);
      8'h4E:   exp_rd = 16'h7808 | {10'h000, an_done, 2'b00, link_up, 2'b00};
      8'h50:   exp_rd = ID_LO;
      8'h52:   exp_rd = ID_HI;
      8'h54:   exp_rd = 16'(adv_m) | 16'h0001;
      default: exp_rd = 16'h0000;
    endcase
    if (!rd) exp_rd = 16'h0000;
    rs = (ac && ad[9]) || (wr && w == 8'h4C && be[1] && d[9]);
    // alias first so that host lanes win the same edge
    if (ac) ctrl_m = (ctrl_m & ~32'h793E) | (ad & 16'h793E);
    if (aa) adv_m = (adv_m & ~32'h05E0) | (ad & 16'h05E0);
    if (wr && w == 8'h4C) ctrl_m = (ctrl_m & ~(lm & 16'h793F)) |
                                   (d & lm & 16'h793F);
    if (wr && w == 8'h54) adv_m = (adv_m & ~(lm & 16'h07E0)) |
                                  (d & lm & 16'h07E0);
    @(negedge i_mclk);
    chk_rd({15'h0000, o_reg_ack}, {15'h0000, wr | rd});
    chk_rd(o_reg_rdata, exp_rd);
    chk_pulse(rst_p, rs);
    chk_out(out_c, 16'(ctrl_m) & 16'h793A);
    chk_out(out_a, 16'(adv_m) & 16'h05E0);
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_alias_ctrl_we = 1'b0;
    i_alias_adv_we = 1'b0;
  endtask : xfer

  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(53));
    {i_reg_wr, i_reg_rd, i_alias_ctrl_we, i_alias_adv_we, slow} = '0;
    {i_reg_addr, i_reg_be, i_reg_wdata, i_alias_data} = '0;
    i_reset = 1'b1;
    ctrl_m = 32'h3120;
    adv_m = 32'h05E0;
    repeat (10) @(negedge i_mclk);
    i_reset = 1'b0;
    foreach (addrs[k]) xfer(0, 1, addrs[k], 2'b11, 16'h0000);
    $display("test reset_values done");
    foreach (cbits[k]) begin
      xfer(1, 0, 8'h4C, 2'b11, 16'(ctrl_m ^ (1 << cbits[k])));
      xfer(0, 1, 8'h4C, 2'b11, 16'h0000);
    end
    for (int b = 5; b <= 10; b++) begin
      xfer(1, 0, 8'h54, 2'b11, 16'(adv_m ^ (1 << b)));
      xfer(0, 1, 8'h54, 2'b11, 16'h0000);
    end
    xfer(1, 0, 8'h4C, 2'b11, 16'hFFFF);
    xfer(0, 1, 8'h4C, 2'b11, 16'h0000);
    xfer(1, 0, 8'h4C, 2'b01, 16'h0200);
    xfer(1, 1, 8'h4C, 2'b10, 16'h0000);
    xfer(1, 1, 8'h54, 2'b01, 16'hFFFF);
    foreach (addrs[k]) xfer(1, 1, addrs[k], 2'b11, 16'hFFFF);
    $display("test control_bits done");
    slow = 1'b1;
    xfer(1, 0, 8'h4C, 2'b11, 16'h1200);
    repeat (45) xfer(0, 1, 8'h4E, 2'b11, 16'h0000);
    xfer(1, 0, 8'h4C, 2'b11, 16'h1800);
    xfer(0, 1, 8'h4E, 2'b11, 16'h0000);
    xfer(1, 0, 8'h4C, 2'b11, 16'h2100);
    xfer(0, 1, 8'h4E, 2'b11, 16'h0000);
    xfer(1, 0, 8'h4C, 2'b11, 16'h2102);
    xfer(0, 1, 8'h4E, 2'b11, 16'h0000);
    slow = 1'b0;
    $display("test link_status done");
    xfer(0, 0, 8'h00, 2'b00, 16'h0000, 1, 1, 16'hFFFF);
    xfer(0, 1, 8'h4C, 2'b11, 16'h0000);
    xfer(1, 1, 8'h4C, 2'b01, 16'h0000, 1, 0, 16'h2000);
    xfer(1, 1, 8'h54, 2'b10, 16'h0000, 0, 1, 16'h0120);
    $display("test alias done");
    repeat (80) begin
      xfer(1'($urandom_range(1)), 1'($urandom_range(1)),
           addrs[$urandom_range(9)], 2'($urandom_range(3)),
           16'($urandom), 1'($urandom_range(1)), 1'($urandom_range(1)),
           16'($urandom));
    end
    $display("test random done");
    end_sim();
  end
endmodule : port_phy_mii_register_bank_tb
`default_nettype wire
